// [core/hmcg_dev.sv]
// Function
// - Handshake lines are asserted when low
// - Serial data lines rest high when idle
// - Incoming-call low while remote starts connecting
// - Link-up low while any connection live
// - Host drives host-ready from terminal-ready
// - Host holds host-ready in high speed
// - High speed host-ready drop: disconnect or command
// - Lines set as input/output with pulls
// - Reset: lines are inputs, weak pull-down
// - Shared line may act as module-ready
// - Lines reached through settings 621 to 628
// - Analogue readings in settings 701, 702
// - Up to seven connected slaves supported
// - Incoming-call line direction programmable
// - Reset input active high
`timescale 1ns/1ps
`default_nettype none
`include "hmcg_map.svh"
// ==========================================================
// Module end: handshake lines, general I/O and setting port
module hmcg_dev
  import hmcg_pkg::*;
(
  input wire logic i_clk, // 40 MHz clock
  input wire logic i_rst, // Async reset, active high
  input wire logic i_set_req, // Setting access request
  input wire logic i_set_we, // Request is a write
  input wire logic [9:0] i_set_num, // Setting register number
  input wire logic [7:0] i_set_wdata, // Write data
  output logic o_set_ack, // One-cycle completion pulse
  output logic [7:0] o_set_rdata, // Read data, valid with ack
  input wire logic i_ring, // Remote device is connecting
  input wire logic [2:0] i_link_count, // Live connections, 0 to 7
  input wire logic [7:0] i_adc0, // Analogue input 0 reading
  input wire logic [7:0] i_adc1, // Analogue input 1 reading
  input wire logic i_rx_room, // Receiver can take data
  output logic o_drop_conn, // Pulse: drop the connection
  output logic o_online_cmd, // Pulse: enter online command mode
  output logic o_high_speed, // High speed mode selected
  hmcg_link_if.dev link // Serial port and I/O pins
);
  // ==========================================================
  // State
  localparam hmcg_dev_state_t DEV_RST = '{
    ack: 1'b0,
    rdata: 8'h00,
    hspeed: 1'b0,
    hs_online: 1'b0,
    shared_sel: 1'b0,
    ready_on: 1'b0,
    ic_dir_in: 1'b0,
    gio_cfg: {7{`HMCG_CFG_RST}},
    gio_in: 7'h00,
    hr_q: 1'b1,
    drop: 1'b0,
    online: 1'b0,
    ic_n: 1'b1,
    ic_oe: 1'b1,
    link_n: 1'b1,
    rts_n: 1'b1
  };
  hmcg_dev_state_t s;
  hmcg_dev_state_t next_s;
  logic [2:0] gio_idx;
  logic gio_hit;
  logic hr_released;
  logic live;

  // ==========================================================
  // Decode helpers
  assign gio_idx = 3'(i_set_num - `HMCG_S_GIO_FIRST);
  assign gio_hit = (i_set_num >= `HMCG_S_GIO_FIRST) &&
    (i_set_num <= `HMCG_S_GIO_LAST);
  // Any of up to seven slaves keeps the link up
  assign live = (i_link_count != 3'h0);
  // Rising host-ready pin means the host deasserted it
  assign hr_released = link.host_ready_n && !s.hr_q;

  // ==========================================================
  // Next state
  always_comb
  begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.drop = 1'b0;
    next_s.online = 1'b0;
    // Ack is a separate cycle, so a write lands before the next take
    if (i_set_req && !s.ack)
    begin
      next_s.ack = 1'b1;
      next_s.rdata = 8'h00;
      if (gio_hit)
      begin
        next_s.rdata = {3'h0, s.gio_cfg[gio_idx]};
        if (i_set_we)
        begin
          next_s.gio_cfg[gio_idx] = i_set_wdata[4:0];
        end
      end
      else
      begin
        case (i_set_num)
          `HMCG_S_HSPEED:
          begin
            next_s.rdata = {6'h00, s.hs_online, s.hspeed};
            if (i_set_we)
            begin
              next_s.hspeed = i_set_wdata[0];
              next_s.hs_online = i_set_wdata[1];
            end
          end
          `HMCG_S_SHARED:
          begin
            next_s.rdata = {7'h00, s.shared_sel};
            if (i_set_we)
            begin
              next_s.shared_sel = i_set_wdata[0];
            end
          end
          `HMCG_S_READY:
          begin
            next_s.rdata = {7'h00, s.ready_on};
            if (i_set_we)
            begin
              next_s.ready_on = i_set_wdata[0];
            end
          end
          `HMCG_S_ICDIR:
          begin
            next_s.rdata = {6'h00, link.ic_level, s.ic_dir_in};
            if (i_set_we)
            begin
              next_s.ic_dir_in = i_set_wdata[0];
            end
          end
          `HMCG_S_SLAVES:
          begin
            next_s.rdata = {5'h00, i_link_count};
          end
          `HMCG_S_GIO_LVL:
          begin
            next_s.rdata = {1'b0, s.gio_in};
            if (i_set_we)
            begin
              for (int k = 0; k < 7; k++)
              begin
                next_s.gio_cfg[k][`HMCG_CFG_LVL] = i_set_wdata[k];
              end
            end
          end
          `HMCG_S_ADC0:
          begin
            next_s.rdata = i_adc0;
          end
          `HMCG_S_ADC1:
          begin
            next_s.rdata = i_adc1;
          end
          default:
          begin
            next_s.rdata = 8'h00;
          end
        endcase
      end
    end
    // Pin levels seen by software
    next_s.gio_in = link.gio_level;
    next_s.hr_q = link.host_ready_n;
    // Host relies on high speed only while it keeps host-ready low
    if (s.hspeed && live && hr_released)
    begin
      next_s.drop = !s.hs_online;
      next_s.online = s.hs_online;
    end
    // Active-low handshakes from the module
    next_s.ic_n = !i_ring;
    next_s.ic_oe = !next_s.ic_dir_in;
    next_s.link_n = !live;
    next_s.rts_n = !i_rx_room;
  end

  // ==========================================================
  // Registers; reset loads constants only
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s <= DEV_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign o_set_ack = s.ack;
  assign o_set_rdata = s.rdata;
  assign o_drop_conn = s.drop;
  assign o_online_cmd = s.online;
  assign o_high_speed = s.hspeed;
  assign link.ic_dev_o = s.ic_n;
  assign link.ic_dev_oe = s.ic_oe;
  assign link.link_up_n = s.link_n;
  assign link.rts_n = s.rts_n;
  // No framing here, so transmit data stays at the idle level
  assign link.txd = 1'b1;

  // ==========================================================
  // Line pads; line 0 is the shared line
  for (genvar g = 0; g < 7; g++)
  begin : g_line
    hmcg_gio_cell u_cell (
      .i_cfg(s.gio_cfg[g]),
      .i_alt_en((g == 0) ? s.shared_sel : 1'b0),
      .i_alt_lvl(!s.ready_on),
      .o_out(link.gio_o[g]),
      .o_oe(link.gio_oe[g]),
      .o_pull_en(link.gio_pull_en[g]),
      .o_pull_up(link.gio_pull_up[g]),
      .o_strong(link.gio_strong[g])
    );
  end
endmodule
`default_nettype wire

// [shared/hmcg_map.svh]
`ifndef HMCG_MAP_SVH
`define HMCG_MAP_SVH
// ==========================================================
// Setting register numbers (decimal in comments)
`define HMCG_S_HSPEED 10'h1fb
// 507
`define HMCG_S_SHARED 10'h228
// 552
`define HMCG_S_READY 10'h229
// 553
`define HMCG_S_ICDIR 10'h230
// 560
`define HMCG_S_SLAVES 10'h231
// 561
`define HMCG_S_GIO_FIRST 10'h26d
// 621
`define HMCG_S_GIO_LAST 10'h273
// 627
`define HMCG_S_GIO_LVL 10'h274
// 628
`define HMCG_S_ADC0 10'h2bd
// 701
`define HMCG_S_ADC1 10'h2be
// 702
// ==========================================================
// Per-line configuration field positions
`define HMCG_CFG_LVL 0
`define HMCG_CFG_DIR 1
`define HMCG_CFG_PEN 2
`define HMCG_CFG_PUP 3
`define HMCG_CFG_STR 4
`define HMCG_CFG_RST 5'h04
// ==========================================================
// Host side Avalon byte addresses and fields
`define HMCG_A_CTRL 4'h0
`define HMCG_A_STAT 4'h4
`define HMCG_A_IRQ 4'h8
`define HMCG_A_MASK 4'hc
`define HMCG_CTRL_TRDY 0
`define HMCG_CTRL_CTS 1
`define HMCG_CTRL_RING 2
`define HMCG_EV_RING 0
`define HMCG_EV_UP 1
`define HMCG_EV_DOWN 2
`endif

// [shared/hmcg_pkg.sv]
`default_nettype none
package hmcg_pkg;
  // ==========================================================
  // Module end state
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic hspeed;
    logic hs_online;
    logic shared_sel;
    logic ready_on;
    logic ic_dir_in;
    logic [6:0][4:0] gio_cfg;
    logic [6:0] gio_in;
    logic hr_q;
    logic drop;
    logic online;
    logic ic_n;
    logic ic_oe;
    logic link_n;
    logic rts_n;
  } hmcg_dev_state_t;
  // ==========================================================
  // Host end state
  typedef struct packed {
    logic wreq;
    logic [31:0] rdata;
    logic [2:0] ctrl;
    logic [2:0] stat;
    logic [2:0] mask;
    logic irq;
    logic ic_q;
    logic link_q;
    logic hr_n;
    logic cts_n;
    logic ic_oe;
  } hmcg_host_state_t;
endpackage
`default_nettype wire

// [shared/hmcg_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Serial-port handshake and general I/O wiring between ends
interface hmcg_link_if;
  logic ic_dev_o;
  logic ic_dev_oe;
  logic ic_host_o;
  logic ic_host_oe;
  logic ic_level;
  logic link_up_n;
  logic host_ready_n;
  logic cts_n;
  logic rts_n;
  logic txd;
  logic rxd;
  logic [6:0] gio_o;
  logic [6:0] gio_oe;
  logic [6:0] gio_pull_en;
  logic [6:0] gio_pull_up;
  logic [6:0] gio_strong;
  logic [6:0] gio_ext_o;
  logic [6:0] gio_ext_oe;
  logic [6:0] gio_level;
  // Incoming-call line idles high through its pull-up
  assign ic_level = ic_dev_oe ? ic_dev_o : (ic_host_oe ? ic_host_o : 1'b1);
  // Module drive wins, then outside drive, then the pull
  assign gio_level = (gio_oe & gio_o) |
    (~gio_oe & gio_ext_oe & gio_ext_o) |
    (~gio_oe & ~gio_ext_oe & gio_pull_en & gio_pull_up);
  modport dev (
    output ic_dev_o, ic_dev_oe, link_up_n, rts_n, txd,
    output gio_o, gio_oe, gio_pull_en, gio_pull_up, gio_strong,
    input ic_level, host_ready_n, cts_n, rxd, gio_level
  );
  modport host (
    output ic_host_o, ic_host_oe, host_ready_n, cts_n, rxd,
    input ic_level, link_up_n, rts_n, txd
  );
endinterface
`default_nettype wire

// [core/hmcg_gio_cell.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hmcg_map.svh"
// ==========================================================
// One general I/O line: decodes its stored setting to pad controls
module hmcg_gio_cell
  import hmcg_pkg::*;
(
  input wire logic [4:0] i_cfg, // Stored line setting
  input wire logic i_alt_en, // Line taken over as module-ready
  input wire logic i_alt_lvl, // Level for module-ready use
  output logic o_out, // Pad output level
  output logic o_oe, // Pad output enable
  output logic o_pull_en, // Pull enabled
  output logic o_pull_up, // Pull up, else down
  output logic o_strong // Strong pull, else weak
);
  // Alternate function forces a driven output
  always_comb
  begin
    o_out = i_alt_en ? i_alt_lvl : i_cfg[`HMCG_CFG_LVL];
    o_oe = i_alt_en | i_cfg[`HMCG_CFG_DIR];
    o_pull_en = i_cfg[`HMCG_CFG_PEN];
    o_pull_up = i_cfg[`HMCG_CFG_PUP];
    o_strong = i_cfg[`HMCG_CFG_STR];
  end
endmodule
`default_nettype wire

// [core/hmcg_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hmcg_map.svh"
// ==========================================================
// Host end: Avalon-MM slave holding terminal control and events
module hmcg_host
  import hmcg_pkg::*;
(
  input wire logic i_clk, // 40 MHz clock
  input wire logic i_rst, // Async reset, active high
  input wire logic [3:0] i_avs_address, // Byte address
  input wire logic i_avs_read, // Read request
  input wire logic i_avs_write, // Write request
  input wire logic [31:0] i_avs_writedata, // Write data
  output logic [31:0] o_avs_readdata, // Read data
  output logic o_avs_waitrequest, // Stall, low to complete
  output logic o_irq, // Level interrupt
  hmcg_link_if.host link // Serial port pins
);
  // ==========================================================
  // State
  localparam hmcg_host_state_t HOST_RST = '{
    wreq: 1'b1,
    rdata: 32'h0,
    ctrl: 3'h0,
    stat: 3'h0,
    mask: 3'h0,
    irq: 1'b0,
    ic_q: 1'b1,
    link_q: 1'b1,
    hr_n: 1'b1,
    cts_n: 1'b1,
    ic_oe: 1'b0
  };
  hmcg_host_state_t s;
  hmcg_host_state_t next_s;
  logic [2:0] ev;
  logic [2:0] clr;
  logic req;

  assign req = i_avs_read | i_avs_write;
  // Edges on the active-low lines from the module
  assign ev[`HMCG_EV_RING] = s.ic_q && !link.ic_level;
  assign ev[`HMCG_EV_UP] = s.link_q && !link.link_up_n;
  assign ev[`HMCG_EV_DOWN] = !s.link_q && link.link_up_n;

  // ==========================================================
  // Next state
  always_comb
  begin
    next_s = s;
    next_s.wreq = 1'b1;
    clr = 3'h0;
    // One wait cycle, then complete at the edge with waitrequest low
    if (req && s.wreq)
    begin
      next_s.wreq = 1'b0;
      case (i_avs_address)
        `HMCG_A_CTRL: next_s.rdata = {29'h0, s.ctrl};
        `HMCG_A_STAT: next_s.rdata = {29'h0, !link.rts_n,
          !link.link_up_n, !link.ic_level};
        `HMCG_A_IRQ: next_s.rdata = {29'h0, s.stat};
        `HMCG_A_MASK: next_s.rdata = {29'h0, s.mask};
        default: next_s.rdata = 32'h0;
      endcase
    end
    if (i_avs_write && !s.wreq)
    begin
      case (i_avs_address)
        `HMCG_A_CTRL: next_s.ctrl = i_avs_writedata[2:0];
        `HMCG_A_IRQ: clr = i_avs_writedata[2:0];
        `HMCG_A_MASK: next_s.mask = i_avs_writedata[2:0];
        default: next_s.ctrl = s.ctrl;
      endcase
    end
    // A new event beats a clear in the same cycle
    next_s.stat = (s.stat & ~clr) | ev;
    next_s.irq = |(next_s.stat & next_s.mask);
    next_s.ic_q = link.ic_level;
    next_s.link_q = link.link_up_n;
    // Terminal-ready drives host-ready; software keeps it set
    next_s.hr_n = !next_s.ctrl[`HMCG_CTRL_TRDY];
    next_s.cts_n = !next_s.ctrl[`HMCG_CTRL_CTS];
    // Open-drain style pull-low whenever the ring control bit is set
    next_s.ic_oe = next_s.ctrl[`HMCG_CTRL_RING];
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s <= HOST_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign o_avs_readdata = s.rdata;
  assign o_avs_waitrequest = s.wreq;
  assign o_irq = s.irq;
  assign link.host_ready_n = s.hr_n;
  assign link.cts_n = s.cts_n;
  assign link.ic_host_o = 1'b0;
  assign link.ic_host_oe = s.ic_oe;
  // No framing here, so receive data stays at the idle level
  assign link.rxd = 1'b1;
endmodule
`default_nettype wire

// [tb/hmcg_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Pin checks on the link between the two ends
module hmcg_assertions (
  input wire logic i_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic ic_dev_o, // Module level
  input wire logic ic_dev_oe, // Module enable
  input wire logic ic_host_o, // Host level
  input wire logic ic_host_oe, // Host enable
  input wire logic ic_level, // Resolved line
  input wire logic link_up_n, // Link-up
  input wire logic host_ready_n, // Host-ready
  input wire logic cts_n, // Clear-to-send
  input wire logic rts_n, // Request-to-send
  input wire logic txd, // Module data
  input wire logic rxd, // Host data
  input wire logic [6:0] gio_o, // Levels
  input wire logic [6:0] gio_oe, // Enables
  input wire logic [6:0] gio_pull_en, // Pulls on
  input wire logic [6:0] gio_pull_up, // Pulls up
  input wire logic [6:0] gio_strong, // Strong pulls
  input wire logic [6:0] gio_level // Resolved lines
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // ==========================================================
  // Properties
  // The first edge after a release still shows the reset values
  sequence s_rel;
    $past(i_rst);
  endsequence
  property p_tx_idle;
    txd;
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("txd not idle");
  property p_rx_idle;
    rxd;
  endproperty
  a_rx_idle: assert property (p_rx_idle)
    else $error("rxd not idle");
  property p_gio_rst;
    s_rel |-> gio_oe == 7'h00 && gio_pull_en == 7'h7f &&
      gio_pull_up == 7'h00 && gio_strong == 7'h00;
  endproperty
  a_gio_rst: assert property (p_gio_rst)
    else $error("lines not weak pull-down inputs");
  property p_dev_rst;
    s_rel |-> link_up_n && ic_dev_o && ic_dev_oe && rts_n;
  endproperty
  a_dev_rst: assert property (p_dev_rst)
    else $error("module lines not deasserted");
  property p_host_rst;
    s_rel |-> host_ready_n && cts_n && !ic_host_oe;
  endproperty
  a_host_rst: assert property (p_host_rst)
    else $error("host lines not deasserted");
  // Host can only pull the incoming-call line to its asserted level
  property p_ic_host;
    ic_host_oe |-> !ic_host_o;
  endproperty
  a_ic_host: assert property (p_ic_host)
    else $error("host drives line high");
  property p_ic_dir;
    ic_dev_oe |-> ic_level == ic_dev_o && !ic_host_oe;
  endproperty
  a_ic_dir: assert property (p_ic_dir)
    else $error("incoming-call driven by both ends");
  property p_gio_out;
    (gio_level & gio_oe) == (gio_o & gio_oe);
  endproperty
  a_gio_out: assert property (p_gio_out)
    else $error("output line level wrong");
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hmcg_map.svh"
// ==========================================================
// Both ends joined back to back, driven from both user sides
module testbench;
  logic i_clk, i_rst, req, we, ack, ring, room, drop, onl, hs;
  logic [9:0] num;
  logic [7:0] wd, rdat, adc0, adc1;
  logic [2:0] cnt;
  logic [3:0] adr;
  logic rd, wr, wreq, irq;
  logic [31:0] wdat, avr, got;
  logic [4:0] cfg [7];
  logic [4:0] pin;
  logic [6:0] wd7;
  int num_errors, check_count, cyc, ndrop, nonl, seed;
  hmcg_link_if lnk ();
  hmcg_dev hmcg_dev_inst (.i_clk(i_clk), .i_rst(i_rst), .i_set_req(req),
    .i_set_we(we), .i_set_num(num), .i_set_wdata(wd), .o_set_ack(ack),
    .o_set_rdata(rdat), .i_ring(ring), .i_link_count(cnt), .i_adc0(adc0),
    .i_adc1(adc1), .i_rx_room(room), .o_drop_conn(drop),
    .o_online_cmd(onl), .o_high_speed(hs), .link(lnk.dev));
  hmcg_host hmcg_host_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdat), .o_avs_readdata(avr),
    .o_avs_waitrequest(wreq), .o_irq(irq), .link(lnk.host));
  hmcg_assertions hmcg_assertions_inst (.i_clk(i_clk), .i_rst(i_rst),
    .ic_dev_o(lnk.ic_dev_o), .ic_dev_oe(lnk.ic_dev_oe),
    .ic_host_o(lnk.ic_host_o), .ic_host_oe(lnk.ic_host_oe),
    .ic_level(lnk.ic_level), .link_up_n(lnk.link_up_n),
    .host_ready_n(lnk.host_ready_n), .cts_n(lnk.cts_n),
    .rts_n(lnk.rts_n), .txd(lnk.txd), .rxd(lnk.rxd), .gio_o(lnk.gio_o),
    .gio_oe(lnk.gio_oe), .gio_pull_en(lnk.gio_pull_en),
    .gio_pull_up(lnk.gio_pull_up), .gio_strong(lnk.gio_strong),
    .gio_level(lnk.gio_level));
  // ==========================================================
  // Helpers
  task automatic summarize();
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  // Setting access, held until the acknowledge is seen
  task automatic sset(input logic w, input logic [9:0] n,
    input logic [7:0] d);
    @(posedge i_clk);
    req <= 1'b1;
    we <= w;
    num <= n;
    wd <= d;
    do @(posedge i_clk); while (ack !== 1'b1);
    got = {24'h0, rdat};
    req <= 1'b0;
  endtask
  // Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    @(posedge i_clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do @(posedge i_clk); while (wreq !== 1'b0);
    got = avr;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Resolved line levels: own drive, then outside drive, then pull
  function automatic logic [6:0] lvl();
    for (int i = 0; i < 7; i++)
      lvl[i] = cfg[i][1] ? cfg[i][0] : (lnk.gio_ext_oe[i] ?
        lnk.gio_ext_o[i] : cfg[i][2] & cfg[i][3]);
  endfunction
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Pulse counter and hang guard; a hang ends the run as a mismatch
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    ndrop <= ndrop + int'(drop === 1'b1);
    nonl <= nonl + int'(onl === 1'b1);
    if (cyc == 20000)
    begin
      num_errors++;
      summarize();
    end
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    seed = 32'hdc84;
    {req, we, ring, room, rd, wr, num, wd, cnt, adr, wdat} = '0;
    {adc0, adc1, lnk.gio_ext_o, lnk.gio_ext_oe} = '0;
    i_rst = 1'b1;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      sset(1'b0, `HMCG_S_GIO_FIRST + 10'(i), 8'h00);
      chk("cfg rst", 32'h04, got);
      cfg[i] = 5'($random(seed));
      sset(1'b1, `HMCG_S_GIO_FIRST + 10'(i), {3'h0, cfg[i]});
      pin = {lnk.gio_strong[i], lnk.gio_pull_up[i], lnk.gio_pull_en[i],
        lnk.gio_oe[i], lnk.gio_oe[i] & lnk.gio_o[i]};
      chk("pins", {cfg[i][4:1], cfg[i][1] & cfg[i][0]}, pin);
      sset(1'b0, `HMCG_S_GIO_FIRST + 10'(i), 8'h00);
      chk("cfg rd", cfg[i], got);
    end
    // Outside world drives some lines; level write sets the level bit of all seven lines
    lnk.gio_ext_o <= 7'($random(seed));
    lnk.gio_ext_oe <= 7'($random(seed));
    wd7 = 7'($random(seed));
    sset(1'b1, `HMCG_S_GIO_LVL, {1'b0, wd7});
    for (int i = 0; i < 7; i++)
      cfg[i][0] = wd7[i];
    sset(1'b0, `HMCG_S_GIO_LVL, 8'h00);
    chk("levels", lvl(), got);
    sset(1'b1, `HMCG_S_SHARED, 8'h01);
    for (int r = 0; r < 2; r++)
    begin
      sset(1'b1, `HMCG_S_READY, 8'(r));
      chk("ready", {1'b1, ~r[0]}, {lnk.gio_oe[0], lnk.gio_o[0]});
    end
    sset(1'b1, `HMCG_S_SHARED, 8'h00);
    adc0 <= 8'($random(seed));
    adc1 <= 8'($random(seed));
    for (int a = 0; a < 3; a++)
    begin
      sset(1'b0, a == 2 ? 10'h3ff : `HMCG_S_ADC0 + 10'(a), 8'h00);
      chk("adc", a == 0 ? adc0 : (a == 1 ? adc1 : 8'h00), got);
    end
    // Ring event is masked first, then unmasked, then cleared
    room <= 1'b1;
    bus(1'b1, `HMCG_A_MASK, 32'h6);
    ring <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk("ring", 2'b00, {lnk.ic_level, irq});
    bus(1'b0, `HMCG_A_STAT, 32'h0);
    chk("stat", 32'h5, got);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, got);
    bus(1'b1, `HMCG_A_MASK, 32'h7);
    repeat (2) @(posedge i_clk);
    chk("irq on", 1'b1, irq);
    ring <= 1'b0;
    bus(1'b1, `HMCG_A_IRQ, 32'h1);
    repeat (2) @(posedge i_clk);
    chk("irq clr", {1'b1, 1'b0}, {lnk.ic_level, irq});
    cnt <= 3'h7;
    repeat (3) @(posedge i_clk);
    chk("link", 1'b0, lnk.link_up_n);
    sset(1'b0, `HMCG_S_SLAVES, 8'h00);
    chk("slaves", 32'h7, got);
    cnt <= 3'h0;
    repeat (3) @(posedge i_clk);
    bus(1'b0, `HMCG_A_IRQ, 32'h0);
    chk("events", 32'h6, got);
    chk("link down", 1'b1, lnk.link_up_n);
    bus(1'b1, `HMCG_A_IRQ, 32'h7);
    // Drop, then online command, then high speed off: no pulse
    cnt <= 3'h2;
    for (int m = 0; m < 3; m++)
    begin
      sset(1'b1, `HMCG_S_HSPEED, m == 2 ? 8'h00 : 8'(2 * m + 1));
      chk("hs", m != 2, hs);
      bus(1'b1, `HMCG_A_CTRL, 32'h3);
      repeat (2) @(posedge i_clk);
      chk("hr", 2'b00, {lnk.host_ready_n, lnk.cts_n});
      bus(1'b1, `HMCG_A_CTRL, 32'h0);
      repeat (4) @(posedge i_clk);
      chk("pulses", m > 0 ? 32'h10001 : 32'h10000,
        {ndrop[15:0], nonl[15:0]});
    end
    sset(1'b1, `HMCG_S_ICDIR, 8'h01);
    for (int v = 0; v < 2; v++)
    begin
      bus(1'b1, `HMCG_A_CTRL, v == 1 ? 32'h0 : 32'h4);
      repeat (2) @(posedge i_clk);
      sset(1'b0, `HMCG_S_ICDIR, 8'h00);
      chk("ic dir", {1'b0, v[0]}, {lnk.ic_dev_oe, got[1]});
    end
    summarize();
  end
endmodule
`default_nettype wire
